/* hw/temp_mon_cfg.svh */
`ifndef TEMP_MON_CFG_SVH
`define TEMP_MON_CFG_SVH

// command-byte pointer values of the registers held here
`define ADDR_OPERATING_CONTROL 8'h41
`define ADDR_WARNING_MASKS     8'h42
`define ADDR_OVERTEMP_MASKS    8'h43
`define ADDR_WARNING_FLAGS     8'h44

// reset values
`define RST_OPERATING_CONTROL  8'h00
`define RST_WARNING_MASKS      8'h00
`define RST_OVERTEMP_MASKS     8'h00
`define RST_WARNING_FLAGS      8'h00

// operating_control fields
`define BIT_STANDBY_REQUEST    7
`define BIT_SOFT_RESET_REQUEST 6
`define BIT_BUS_TIMEOUT_DIS    5
`define BIT_CH1_FAST_CONVERT   4
`define BIT_CH1_SERIES_R_CANCEL 3

// warning_output_masks / warning_flags fields
`define BIT_LOCAL_CHANNEL      6
`define BIT_CH1                0
`define BIT_CH4                3

// writable / implemented bits per register
`define WMASK_OPERATING_CONTROL 8'hb8
`define WMASK_WARNING_MASKS    8'h4f
`define WMASK_OVERTEMP_MASKS   8'h09
`define WMASK_WARNING_FLAGS    8'h4f

// series-resistance cancellation extra conversion time
`define RCANCEL_EXTRA_MS       125
`define CLK_FREQ_HZ            100000000
`define RCANCEL_EXTRA_CYCLES   ((`RCANCEL_EXTRA_MS * `CLK_FREQ_HZ) / 1000)

`endif

/* hw/temp_mon_pkg.sv */
package temp_mon_pkg;

  typedef logic [7:0] reg_byte_t;

  // gray sequence idle -> extend -> report
  typedef enum logic [1:0] {
    EXT_IDLE   = 2'b00,
    EXT_WAIT   = 2'b01,
    EXT_REPORT = 2'b11
  } ext_state_e;

endpackage

/* hw/ch1_ext_if.sv */
`timescale 1ns/100ps
interface ch1_ext_if;
  logic start;
  logic over_in;
  logic extend;
  logic done;
  logic over_out;
  logic busy;

  modport ctrl (output start, output over_in, output extend,
                input done, input over_out, input busy);
  modport timer (input start, input over_in, input extend,
                 output done, output over_out, output busy);
endinterface

/* hw/ch1_extend_timer.sv */
`timescale 1ns/100ps
`include "temp_mon_cfg.svh"
module ch1_extend_timer
  import temp_mon_pkg::*;
#(
  parameter int unsigned EXTRA_CYCLES = `RCANCEL_EXTRA_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic srst,
  ch1_ext_if.timer  ext
);

  localparam int unsigned CW = $clog2(EXTRA_CYCLES + 1);

  ext_state_e      state_q;
  ext_state_e      state_d;
  logic [CW-1:0]   cnt_q;
  logic            over_q;

  wire cnt_last = (cnt_q == CW'(1));

  always_comb begin
    state_d = state_q;
    case (state_q)
      EXT_IDLE:   if (ext.start) state_d = ext.extend ? EXT_WAIT : EXT_REPORT;
      EXT_WAIT:   if (cnt_last) state_d = EXT_REPORT;
      EXT_REPORT: state_d = EXT_IDLE;
      default:    state_d = EXT_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= EXT_IDLE;
      cnt_q   <= '0;
      over_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q == EXT_IDLE && ext.start) begin
        over_q <= ext.over_in;
        cnt_q  <= CW'(EXTRA_CYCLES);
      end else if (state_q == EXT_WAIT) begin
        cnt_q <= cnt_q - CW'(1);
      end
    end
  end

  // the result is held back for the whole extra interval
  assign ext.done     = (state_q == EXT_REPORT);
  assign ext.over_out = over_q;
  assign ext.busy     = (state_q != EXT_IDLE);

endmodule

/* hw/temp_mon_regs.sv */
`timescale 1ns/100ps
`include "temp_mon_cfg.svh"
module temp_mon_regs
  import temp_mon_pkg::*;
#(
  parameter int unsigned RCANCEL_CYCLES = `RCANCEL_EXTRA_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       conv_done,
  input  wire logic [7:0] conv_over,
  input  wire logic       ch1_conv_end,
  input  wire logic       ch1_over,
  input  wire logic       ot_ch1_over,
  input  wire logic       ot_ch4_over,
  input  wire logic       ara_done,
  output logic            conv_halt,
  output logic            bus_timeout_en,
  output logic            ch1_fast_mode,
  output logic            ch1_rcancel_en,
  output logic            ch1_extend_busy,
  output logic            soft_reset_pulse,
  output logic            warn_pin_out,
  output logic            warn_pin_oe,
  output logic            overtemp_shutdown_out_pin_out,
  output logic            overtemp_shutdown_out_pin_oe
);

  reg_byte_t op_ctrl_q;
  reg_byte_t warn_mask_q;
  reg_byte_t ot_mask_q;
  reg_byte_t flags_q;
  reg_byte_t flags_d;
  reg_byte_t rdata_q;
  logic      alert_q;
  logic      alert_d;
  logic      overtemp_shutdown_out_q;
  logic      soft_rst_q;

  ch1_ext_if ext ();

  // address decode
  wire sel_op    = (reg_addr == `ADDR_OPERATING_CONTROL);
  wire sel_wmask = (reg_addr == `ADDR_WARNING_MASKS);
  wire sel_omask = (reg_addr == `ADDR_OVERTEMP_MASKS);
  wire sel_flags = (reg_addr == `ADDR_WARNING_FLAGS);

  wire wr_op    = reg_wr && sel_op;
  wire wr_wmask = reg_wr && sel_wmask;
  wire wr_omask = reg_wr && sel_omask;
  wire rd_flags = reg_rd && sel_flags;

  // soft reset acts one cycle after the write, so the write itself completes first
  wire soft_rst_req = wr_op && reg_wdata[`BIT_SOFT_RESET_REQUEST];
  wire any_rst      = srst || soft_rst_q;

  // channel 1 result goes through the extension timer
  assign ext.start   = ch1_conv_end && !op_ctrl_q[`BIT_STANDBY_REQUEST];
  assign ext.over_in = ch1_over;
  assign ext.extend  = op_ctrl_q[`BIT_CH1_SERIES_R_CANCEL];

  ch1_extend_timer #(
    .EXTRA_CYCLES (RCANCEL_CYCLES)
  ) u_ch1_ext (
    .core_clk (core_clk),
    .srst     (any_rst),
    .ext      (ext.timer)
  );

  // new crossings; conversions are ignored while in standby
  wire       conv_ok = conv_done && !op_ctrl_q[`BIT_STANDBY_REQUEST];
  reg_byte_t set_vec;
  always_comb begin
    set_vec = 8'h00;
    if (conv_ok) begin
      set_vec[`BIT_LOCAL_CHANNEL] = conv_over[`BIT_LOCAL_CHANNEL];
      set_vec[3:1]                = conv_over[3:1];
    end
    if (ext.done) begin
      set_vec[`BIT_CH1] = ext.over_out;
    end
  end

  // set wins over the read clear, so a crossing in the read cycle is kept
  always_comb begin
    flags_d = flags_q;
    if (rd_flags) begin
      flags_d = 8'h00;
    end
    flags_d = (flags_d | set_vec) & `WMASK_WARNING_FLAGS;
  end

  // masked channels still record but never raise the pin
  wire [7:0] unmasked_set = set_vec & ~warn_mask_q;
  always_comb begin
    alert_d = alert_q;
    if (rd_flags || ara_done) begin
      alert_d = 1'b0;
    end
    if (|unmasked_set) begin
      alert_d = 1'b1;
    end
  end

  wire overtemp_shutdown_out_d = (ot_ch1_over && !ot_mask_q[`BIT_CH1]) ||
                 (ot_ch4_over && !ot_mask_q[`BIT_CH4]);

  reg_byte_t rsel;
  assign rsel = sel_op    ? op_ctrl_q   :
                sel_wmask ? warn_mask_q :
                sel_omask ? ot_mask_q   :
                sel_flags ? flags_q     : 8'h00;

  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      op_ctrl_q   <= `RST_OPERATING_CONTROL;
      warn_mask_q <= `RST_WARNING_MASKS;
      ot_mask_q   <= `RST_OVERTEMP_MASKS;
    end else begin
      // bit 6 is never stored, so it reads back as 0
      if (wr_op) op_ctrl_q <= reg_wdata & `WMASK_OPERATING_CONTROL;
      if (wr_wmask) warn_mask_q <= reg_wdata & `WMASK_WARNING_MASKS;
      if (wr_omask) ot_mask_q <= reg_wdata & `WMASK_OVERTEMP_MASKS;
    end
  end

  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      flags_q <= `RST_WARNING_FLAGS;
      alert_q <= 1'b0;
      overtemp_shutdown_out_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      alert_q <= alert_d;
      overtemp_shutdown_out_q <= overtemp_shutdown_out_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      soft_rst_q <= 1'b0;
      rdata_q    <= 8'h00;
    end else begin
      soft_rst_q <= soft_rst_req && !soft_rst_q;
      if (reg_rd) rdata_q <= rsel;
    end
  end

  assign reg_rdata        = rdata_q;
  assign conv_halt        = op_ctrl_q[`BIT_STANDBY_REQUEST];
  assign bus_timeout_en   = !op_ctrl_q[`BIT_BUS_TIMEOUT_DIS];
  assign ch1_fast_mode    = op_ctrl_q[`BIT_CH1_FAST_CONVERT];
  assign ch1_rcancel_en   = op_ctrl_q[`BIT_CH1_SERIES_R_CANCEL];
  assign ch1_extend_busy  = ext.busy;
  assign soft_reset_pulse = soft_rst_q;
  // open-drain pins: pull low while asserted
  assign warn_pin_out     = 1'b0;
  assign warn_pin_oe      = alert_q;
  assign overtemp_shutdown_out_pin_out    = 1'b0;
  assign overtemp_shutdown_out_pin_oe     = overtemp_shutdown_out_q;

endmodule

/* tb/temp_mon_regs_monitor.sv */
`timescale 1ns/100ps
module temp_mon_regs_monitor (
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       conv_done,
  input wire logic       ch1_conv_end,
  input wire logic       ara_done,
  input wire logic       ot_ch1_over,
  input wire logic       ot_ch4_over,
  input wire logic       conv_halt,
  input wire logic       bus_timeout_en,
  input wire logic       ch1_extend_busy,
  input wire logic       soft_reset_pulse,
  input wire logic       warn_pin_oe,
  input wire logic       overtemp_shutdown_out_pin_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // requests in the soft reset cycle are lost, so they prove nothing
  wire cfg_wr = reg_wr && reg_addr == 8'h41 && !soft_reset_pulse;
  wire quiet  = !conv_done && !ch1_conv_end && !ch1_extend_busy;
  // the host releases its data after the strobe, so the written value is taken one cycle back
  halt_bit_a: assert property (cfg_wr |=> conv_halt == $past(reg_wdata[7]))
    else $error("standby level wrong");
  timeout_bit_a: assert property (cfg_wr |=> bus_timeout_en == !$past(reg_wdata[5]))
    else $error("timeout enable wrong");
  soft_reset_a: assert property (cfg_wr && reg_wdata[6] |=> soft_reset_pulse ##1
    (!soft_reset_pulse && !conv_halt && bus_timeout_en && !warn_pin_oe))
    else $error("soft reset sequence wrong");
  warn_clear_a: assert property (((reg_rd && reg_addr == 8'h44) || ara_done) && quiet
    && !$past(ch1_conv_end) |=> !warn_pin_oe) else $error("warning pin not cleared");
  standby_ignore_a: assert property (conv_halt && conv_done && !warn_pin_oe
    && !ch1_conv_end && !ch1_extend_busy |=> !warn_pin_oe)
    else $error("conversion taken in standby");
  overtemp_shutdown_out_idle_a: assert property (!ot_ch1_over && !ot_ch4_over |=> !overtemp_shutdown_out_pin_oe)
    else $error("overtemp pin without cause");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  unmapped_zero_a: assert property (reg_rd && !(reg_addr inside {[8'h41:8'h44]})
    && !soft_reset_pulse |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule

/* tb/smbus_host_model.sv */
`timescale 1ns/100ps
module smbus_host_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h00000;
  // released lines show the inverse so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge core_clk);
    {reg_addr, reg_wdata, reg_wr} = {a, v, 1'b1};
    @(negedge core_clk);
    {reg_addr, reg_wdata, reg_wr} = {~a, ~v, 1'b0};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge core_clk);
    {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge core_clk);
    {reg_addr, reg_rd} = {~a, 1'b0};
    v = reg_rdata;
  endtask
endmodule

/* tb/temp_mon_regs_tb.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("Error t=%0t got %h want %h", $time, g, e); end end
module temp_mon_regs_tb;
  localparam int unsigned RC = 5;
  logic        core_clk, srst, reg_wr, reg_rd, conv_done, ch1_conv_end, ch1_over, ara_done;
  logic        ot_ch1_over, ot_ch4_over, conv_halt, bus_timeout_en, ch1_fast_mode;
  logic        ch1_rcancel_en, ch1_extend_busy, soft_reset_pulse, warn_pin_out, warn_pin_oe;
  logic        overtemp_shutdown_out_pin_out, overtemp_shutdown_out_pin_oe;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, conv_over, d, x;
  logic [31:0] seed = 32'h00017f22;
  int          fail_count, checks_done, n0, n1;
  temp_mon_regs #(.RCANCEL_CYCLES(RC)) temp_mon_regs_i (.*);
  smbus_host_model smbus_host_model_i (.*);
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic [7:0] exp_reg(input logic [7:0] a, input logic [7:0] v);
    return a == 8'h41 ? v & 8'hb8 : a == 8'h42 ? v & 8'h4f : a == 8'h43 ? v & 8'h09 : 8'h00;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    smbus_host_model_i.wr(a, v);
  endtask
  task automatic rd(input logic [7:0] a);
    smbus_host_model_i.rd(a, d);
  endtask
  // s picks conv_done, ch1_conv_end, ara_done
  task automatic pulse(input logic [2:0] s, input logic [7:0] v);
    @(negedge core_clk);
    {conv_done, ch1_conv_end, ara_done, conv_over, ch1_over} = {s, v, v[0]};
    @(negedge core_clk);
    {conv_done, ch1_conv_end, ara_done, conv_over, ch1_over} = {3'b000, ~v, ~v[0]};
  endtask
  task automatic wait_pin(output int n);
    n = 0;
    while (warn_pin_oe !== 1'b1 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
  endtask
  task automatic check_zero();
    for (int a = 8'h40; a < 8'h46; a++) begin
      rd(a[7:0]);
      `CHK(d, 8'h00)
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #60000;
    fail_count++;
    wrap_up();
  end
  initial begin
    {srst, conv_done, ch1_conv_end, ara_done, ot_ch1_over, ot_ch4_over, ch1_over} = 7'h40;
    conv_over = 8'h00;
    repeat (4) @(negedge core_clk);
    srst = 1'b0;
    `CHK({bus_timeout_en, conv_halt}, 2'b10)
    `CHK({warn_pin_out, overtemp_shutdown_out_pin_out}, 2'b00)
    check_zero();
    repeat (4) for (int a = 8'h41; a < 8'h45; a++) begin
      x = rnd() & (a == 8'h41 ? 8'hbf : 8'hff);
      wr(a[7:0], x);
      rd(a[7:0]);
      `CHK(d, exp_reg(a[7:0], x))
      if (a == 8'h41) `CHK({conv_halt, bus_timeout_en, ch1_fast_mode, ch1_rcancel_en}, {x[7], ~x[5], x[4:3]})
    end
    $display("test registers done");
    wr(8'h42, 8'h4f);
    wr(8'h41, 8'hd8);
    repeat (2) @(negedge core_clk);
    `CHK({conv_halt, ch1_rcancel_en}, 2'b00)
    check_zero();
    x = rnd() | 8'h40;
    pulse(3'b100, x);
    `CHK(warn_pin_oe, 1'b1)
    rd(8'h44);
    `CHK({d, warn_pin_oe}, {x & 8'h4e, 1'b0})
    rd(8'h44);
    `CHK(d, 8'h00)
    pulse(3'b100, x);
    rd(8'h44);
    `CHK(d, x & 8'h4e)
    wr(8'h42, 8'h4f);
    pulse(3'b100, 8'h4e);
    pulse(3'b010, 8'h01);
    repeat (4) @(negedge core_clk);
    `CHK(warn_pin_oe, 1'b0)
    rd(8'h44);
    `CHK(d, 8'h4f)
    wr(8'h42, 8'h00);
    pulse(3'b100, 8'h08);
    `CHK(warn_pin_oe, 1'b1)
    pulse(3'b001, 8'h00);
    `CHK(warn_pin_oe, 1'b0)
    rd(8'h44);
    $display("test flags done");
    pulse(3'b010, 8'h01);
    wait_pin(n0);
    rd(8'h44);
    `CHK(d, 8'h01)
    wr(8'h41, 8'h08);
    pulse(3'b010, 8'h01);
    `CHK(ch1_extend_busy, 1'b1)
    wait_pin(n1);
    `CHK(n1 - n0, RC)
    rd(8'h44);
    wr(8'h41, 8'h80);
    wr(8'h44, 8'hff);
    pulse(3'b100, 8'h4e);
    pulse(3'b010, 8'h01);
    repeat (4) @(negedge core_clk);
    rd(8'h44);
    `CHK({d, warn_pin_oe}, 9'h000)
    for (int i = 0; i < 16; i++) begin
      wr(8'h43, {4'h0, i[3], 2'b00, i[2]});
      {ot_ch1_over, ot_ch4_over} = i[1:0];
      @(negedge core_clk);
      `CHK(overtemp_shutdown_out_pin_oe, (i[1] & ~i[2]) | (i[0] & ~i[3]))
      `CHK({warn_pin_out, overtemp_shutdown_out_pin_out}, 2'b00)
    end
    $display("test ch1 standby overtemp done");
    wrap_up();
  end
endmodule
bind temp_mon_regs temp_mon_regs_monitor temp_mon_regs_monitor_i (.*);
